// ==== lsat_pkg.sv ====
package lsat_pkg;
  // Register offsets (byte addresses of 32-bit words)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_SRC = 8'h0C;
  localparam logic [7:0] OFS_ACT = 8'h10;
  localparam logic [7:0] OFS_PERIOD = 8'h14;
  localparam logic [7:0] OFS_MINPER = 8'h18;
  localparam logic [7:0] OFS_HEIGHT = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_DISARM_BIT = 1;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_GATE_BIT = 1;
  localparam int ST_CNT_LSB = 16;

  localparam int TGT_FRAME = 0;
  localparam int TGT_LINE = 1;

  // Reset values
  localparam logic [31:0] PERIOD_RST = 32'h0000_0FA0;
  localparam logic [31:0] MINPER_RST = 32'h0000_0064;
  localparam logic [15:0] HEIGHT_RST = 16'h0400;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int FILT_TIME_US = 1;
  localparam int FILT_CYCLES = (FILT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = $clog2(FILT_CYCLES + 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);

  typedef enum logic [2:0] {
    ACT_RISE,
    ACT_FALL,
    ACT_ANY,
    ACT_HIGH,
    ACT_LOW
  } act_t;

  typedef struct packed {
    logic mode_on;
    logic src_b;
    act_t act;
  } trig_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  localparam trig_cfg_t CFG_RST = '{mode_on: 1'b0, src_b: 1'b0, act: ACT_RISE};
endpackage : lsat_pkg

// ==== line_scan_acquisition_trigger_ctrl.sv ====
// Function
// - No line capture happens before an arm command has been executed.
// - Disarm ends all capture; capture stays off until a new arm.
// - Only continuous mode; arm stays in force until disarm.
// - Line starts arriving while the frame gate is inactive are discarded.
// - Frame trigger off: gate made internally, opened automatically on arm.
// - Internal gate closes after a full frame, reopens as soon as possible.
// - After disarm the frame gate stays inactive.
// - Frame trigger on: gate taken from external input a or b.
// - Edge frame modes open the gate, which closes after a full frame.
// - Level high: rising edge opens gate, it closes when input goes low.
// - Level low: falling edge opens gate, it closes when input goes high.
// - Line trigger off: internal line starts from arm until disarm.
// - Free-run line starts come at the programmed rate when below maximum.
// - A programmed rate above the maximum is clamped to the maximum.
// - Line trigger on: rising, falling or any edge of chosen input; no level.
// - Each accepted external line edge starts exactly one line capture.
// - Separate mode, source and activation per target, chosen by a selector.
// - External pulses shorter than 1 us are ignored.
// - Lines per frame equal the programmed frame height in internal and edge frame modes.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module line_scan_acquisition_trigger_ctrl
  import lsat_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire reg_req_t i_req,
  output logic [31:0] o_rdata,
  input wire logic i_ext_input_a,
  input wire logic i_ext_input_b,
  output logic o_armed,
  output logic o_frame_gate,
  output logic o_line_start
);

  typedef enum logic [1:0] {
    GATE_OFF,
    GATE_WAIT,
    GATE_OPEN,
    GATE_REST
  } gate_st_t;

  logic [1:0] pin_in;
  logic [1:0] sync1_q, sync2_q, sync3_q;
  logic [1:0] filt_q;
  logic [1:0] filt_prev_q;
  logic [1:0] rise, fall;
  logic armed_q;
  logic sel_q;
  trig_cfg_t cfg_q [2];
  logic [31:0] period_q, minper_q;
  logic [15:0] height_q;
  logic [15:0] line_cnt_q;
  logic [31:0] fr_cnt_q;
  logic [31:0] eff_period;
  logic fr_tick;
  gate_st_t gate_q;
  logic fs_edge, fs_level_end, line_evt, line_go, last_line;
  logic ls_rise, ls_fall, fs_rise, fs_fall, fs_lvl;
  logic arm_cmd, disarm_cmd;

  assign pin_in = {i_ext_input_b, i_ext_input_a};

  // Three-stage synchroniser and 1 us width filter, one per input
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      logic [FILT_W-1:0] cnt_q;
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_in[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
      // A new level is taken only after it held for the full filter time
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          cnt_q <= '0;
          filt_q[g] <= 1'b0;
        end else if (sync2_q[g] == sync3_q[g] && sync3_q[g] != filt_q[g]) begin
          if (cnt_q == FILT_LAST) begin
            filt_q[g] <= sync3_q[g];
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end else begin
          cnt_q <= '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      filt_prev_q <= '0;
    end else begin
      filt_prev_q <= filt_q;
    end
  end

  assign rise = filt_q & ~filt_prev_q;
  assign fall = ~filt_q & filt_prev_q;

  // Register writes
  assign arm_cmd = i_req.wr && i_req.addr == OFS_CMD && i_req.wdata[CMD_ARM_BIT];
  assign disarm_cmd = i_req.wr && i_req.addr == OFS_CMD && i_req.wdata[CMD_DISARM_BIT];

  // Disarm wins over a simultaneous arm
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      armed_q <= 1'b0;
    end else if (disarm_cmd) begin
      armed_q <= 1'b0;
    end else if (arm_cmd) begin
      armed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sel_q <= 1'b0;
      cfg_q[TGT_FRAME] <= CFG_RST;
      cfg_q[TGT_LINE] <= CFG_RST;
      period_q <= PERIOD_RST;
      minper_q <= MINPER_RST;
      height_q <= HEIGHT_RST;
    end else if (i_req.wr) begin
      if (i_req.addr == OFS_SEL) begin
        sel_q <= i_req.wdata[0];
      end else if (i_req.addr == OFS_MODE) begin
        cfg_q[sel_q].mode_on <= i_req.wdata[0];
      end else if (i_req.addr == OFS_SRC) begin
        cfg_q[sel_q].src_b <= i_req.wdata[0];
      end else if (i_req.addr == OFS_ACT) begin
        // Level codes and unknown codes are dropped for line start
        if (i_req.wdata[2:0] <= 3'(ACT_LOW) &&
            (sel_q == 1'(TGT_FRAME) || i_req.wdata[2:0] <= 3'(ACT_ANY))) begin
          cfg_q[sel_q].act <= act_t'(i_req.wdata[2:0]);
        end
      end else if (i_req.addr == OFS_PERIOD) begin
        period_q <= i_req.wdata;
      end else if (i_req.addr == OFS_MINPER) begin
        minper_q <= i_req.wdata;
      end else if (i_req.addr == OFS_HEIGHT) begin
        height_q <= i_req.wdata[15:0];
      end
    end
  end

  // Register reads, data in the following cycle; unmapped reads give zero
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_req.rd) begin
      if (i_req.addr == OFS_SEL) begin
        o_rdata <= {31'h0, sel_q};
      end else if (i_req.addr == OFS_MODE) begin
        o_rdata <= {31'h0, cfg_q[sel_q].mode_on};
      end else if (i_req.addr == OFS_SRC) begin
        o_rdata <= {31'h0, cfg_q[sel_q].src_b};
      end else if (i_req.addr == OFS_ACT) begin
        o_rdata <= {29'h0, cfg_q[sel_q].act};
      end else if (i_req.addr == OFS_PERIOD) begin
        o_rdata <= period_q;
      end else if (i_req.addr == OFS_MINPER) begin
        o_rdata <= minper_q;
      end else if (i_req.addr == OFS_HEIGHT) begin
        o_rdata <= {16'h0, height_q};
      end else if (i_req.addr == OFS_STATUS) begin
        o_rdata <= '0;
        o_rdata[ST_ARMED_BIT] <= armed_q;
        o_rdata[ST_GATE_BIT] <= (gate_q == GATE_OPEN);
        o_rdata[ST_CNT_LSB +: 16] <= line_cnt_q;
      end else begin
        o_rdata <= '0;
      end
    end else begin
      o_rdata <= '0;
    end
  end

  // Free-run line timer; a period below the minimum is raised to it
  assign eff_period = (period_q < minper_q) ? minper_q : period_q;
  assign fr_tick = armed_q && !cfg_q[TGT_LINE].mode_on &&
                   (fr_cnt_q + 32'h1 >= eff_period);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !armed_q || cfg_q[TGT_LINE].mode_on || fr_tick) begin
      fr_cnt_q <= '0;
    end else begin
      fr_cnt_q <= fr_cnt_q + 32'h1;
    end
  end

  // External edges of the selected inputs
  assign ls_rise = rise[cfg_q[TGT_LINE].src_b];
  assign ls_fall = fall[cfg_q[TGT_LINE].src_b];
  assign fs_rise = rise[cfg_q[TGT_FRAME].src_b];
  assign fs_fall = fall[cfg_q[TGT_FRAME].src_b];
  assign fs_lvl = filt_q[cfg_q[TGT_FRAME].src_b];

  always_comb begin
    line_evt = 1'b0;
    if (!cfg_q[TGT_LINE].mode_on) begin
      line_evt = fr_tick;
    end else begin
      case (cfg_q[TGT_LINE].act)
        ACT_RISE: line_evt = ls_rise;
        ACT_FALL: line_evt = ls_fall;
        ACT_ANY: line_evt = ls_rise || ls_fall;
        default: line_evt = 1'b0;
      endcase
    end
  end

  always_comb begin
    fs_edge = 1'b0;
    fs_level_end = 1'b0;
    case (cfg_q[TGT_FRAME].act)
      ACT_RISE: fs_edge = fs_rise;
      ACT_FALL: fs_edge = fs_fall;
      ACT_ANY: fs_edge = fs_rise || fs_fall;
      ACT_HIGH: begin
        fs_edge = fs_rise;
        fs_level_end = !fs_lvl;
      end
      ACT_LOW: begin
        fs_edge = fs_fall;
        fs_level_end = fs_lvl;
      end
      default: fs_edge = 1'b0;
    endcase
  end

  // Line accepted only inside an open gate while armed
  assign line_go = armed_q && gate_q == GATE_OPEN && line_evt;
  assign last_line = ({16'h0, line_cnt_q} + 32'h1 >= {16'h0, height_q});

  // Frame gate sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || disarm_cmd || !armed_q) begin
      gate_q <= GATE_OFF;
    end else begin
      case (gate_q)
        GATE_OFF: begin
          gate_q <= cfg_q[TGT_FRAME].mode_on ? GATE_WAIT : GATE_OPEN;
        end
        GATE_WAIT: begin
          if (!cfg_q[TGT_FRAME].mode_on) begin
            gate_q <= GATE_OPEN;
          end else if (fs_edge) begin
            gate_q <= GATE_OPEN;
          end
        end
        GATE_OPEN: begin
          if (cfg_q[TGT_FRAME].mode_on && fs_level_end) begin
            gate_q <= GATE_WAIT;
          end else if (line_go && last_line && (!cfg_q[TGT_FRAME].mode_on ||
                       cfg_q[TGT_FRAME].act <= ACT_ANY)) begin
            gate_q <= cfg_q[TGT_FRAME].mode_on ? GATE_WAIT : GATE_REST;
          end
        end
        GATE_REST: begin
          // One idle cycle marks the frame boundary before reopening
          gate_q <= cfg_q[TGT_FRAME].mode_on ? GATE_WAIT : GATE_OPEN;
        end
        default: gate_q <= GATE_OFF;
      endcase
    end
  end

  // Lines in the current frame; level gates may run past the height
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || gate_q != GATE_OPEN) begin
      line_cnt_q <= '0;
    end else if (line_go) begin
      line_cnt_q <= last_line ? '0 : line_cnt_q + 16'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_line_start <= 1'b0;
    end else begin
      o_line_start <= line_go;
    end
  end

  assign o_armed = armed_q;
  assign o_frame_gate = (gate_q == GATE_OPEN);

  // Assertions
  sequence s_disarm;
    disarm_cmd;
  endsequence

  sequence s_edge_line;
    armed_q && cfg_q[TGT_LINE].mode_on && gate_q == GATE_OPEN && line_evt;
  endsequence

  AST_NO_LINE_UNARMED: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_line_start |-> $past(armed_q))
    else $error("line start while not armed");

  AST_DISARM_STOPS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_disarm ##1 !arm_cmd |-> ##1 !o_line_start && !armed_q)
    else $error("capture continued after disarm");

  AST_ARM_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    armed_q && !disarm_cmd |=> armed_q)
    else $error("arm dropped without disarm");

  AST_NO_LINE_GATE_SHUT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_line_start |-> $past(o_frame_gate))
    else $error("line start accepted with gate inactive");

  AST_INT_GATE_ON_ARM: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !armed_q && arm_cmd && !disarm_cmd && !cfg_q[TGT_FRAME].mode_on ##1
    !disarm_cmd && !cfg_q[TGT_FRAME].mode_on |=> o_frame_gate)
    else $error("internal gate did not open after arm");

  AST_INT_REOPEN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    gate_q == GATE_REST && !disarm_cmd && armed_q && !cfg_q[TGT_FRAME].mode_on
    |=> o_frame_gate)
    else $error("internal gate did not reopen");

  AST_DISARM_GATE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_disarm |=> !o_frame_gate)
    else $error("gate active after disarm");

  AST_LEVEL_HIGH_END: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_frame_gate && cfg_q[TGT_FRAME].mode_on && cfg_q[TGT_FRAME].act == ACT_HIGH
    && !fs_lvl |=> !o_frame_gate)
    else $error("level high gate stayed open with input low");

  AST_EXT_LINE_ONE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_edge_line |=> o_line_start ##1 !o_line_start || $past(line_go))
    else $error("external line edge not turned into one capture");

  AST_FILTER_WIDTH: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $changed(filt_q[0]) |-> $past(sync3_q[0]) == filt_q[0] &&
    $past(sync3_q[0], FILT_CYCLES) == filt_q[0])
    else $error("input filter accepted a short pulse");

  AST_FREERUN_CLAMP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    fr_tick |-> fr_cnt_q + 32'h1 >= minper_q)
    else $error("free-run faster than the maximum rate");

endmodule : line_scan_acquisition_trigger_ctrl
`default_nettype wire

// ==== ext_trig_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module ext_trig_src (
  input wire logic i_clk,
  output logic o_ext_input_a,
  output logic o_ext_input_b
);
  // Shortest high plus low span the source allows between line edges
  localparam int MIN_SPAN = 120;

  initial begin
    o_ext_input_a = 1'b0;
    o_ext_input_b = 1'b0;
  end

  task automatic drive(input bit sel, input logic val, input int cyc);
    @(posedge i_clk);
    if (sel) begin
      o_ext_input_b <= val;
    end else begin
      o_ext_input_a <= val;
    end
    repeat (cyc) @(posedge i_clk);
  endtask : drive

  task automatic pulse(input bit sel, input int hi, input int lo);
    drive(sel, 1'b1, hi);
    drive(sel, 1'b0, (hi + lo < MIN_SPAN) ? MIN_SPAN - hi : lo);
  endtask : pulse
endmodule : ext_trig_src
`default_nettype wire

// ==== line_scan_acquisition_trigger_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module line_scan_acquisition_trigger_ctrl_tb_top;
  import lsat_pkg::*;
  logic clk = 1'b0;
  logic srst;
  reg_req_t req;
  logic [31:0] rdata;
  logic ext_a;
  logic ext_b;
  logic armed;
  logic gate;
  logic ls;
  int fail_count = 0;
  int checked = 0;
  int ls_cnt = 0;

  always #12.5 clk = ~clk;

  line_scan_acquisition_trigger_ctrl DUT (.i_sys_clk(clk), .i_srst(srst), .i_req(req),
    .o_rdata(rdata), .i_ext_input_a(ext_a), .i_ext_input_b(ext_b), .o_armed(armed),
    .o_frame_gate(gate), .o_line_start(ls));
  ext_trig_src SRC (.i_clk(clk), .o_ext_input_a(ext_a), .o_ext_input_b(ext_b));

  always @(posedge clk) if (ls === 1'b1) ls_cnt <= ls_cnt + 1;

  task automatic report_and_stop();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask : rd

  task automatic cfg(input int tgt, input logic on, input logic srcb, input act_t act);
    wr(OFS_SEL, 32'(tgt));
    wr(OFS_MODE, {31'h0, on});
    wr(OFS_SRC, {31'h0, srcb});
    wr(OFS_ACT, {29'h0, act});
  endtask : cfg

  task automatic wait_gate(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (gate !== v && n < lim);
  endtask : wait_gate

  task automatic wait_ls(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (ls !== 1'b1 && n < lim);
  endtask : wait_ls

  task automatic test_reset();
    logic [31:0] d;
    rd(OFS_PERIOD, d);
    chk(d, PERIOD_RST);
    rd(OFS_MINPER, d);
    chk(d, MINPER_RST);
    rd(OFS_HEIGHT, d);
    chk(d, {16'h0, HEIGHT_RST});
    rd(8'hFC, d);
    chk(d, 32'h0);
    repeat (200) @(posedge clk);
    chk(32'(ls_cnt), 32'h0);
    chk({31'h0, gate}, 32'h0);
    chk({31'h0, armed}, 32'h0);
  endtask : test_reset

  task automatic test_freerun();
    int n;
    int n0;
    logic [31:0] d;
    wr(OFS_HEIGHT, 32'h4);
    wr(OFS_PERIOD, 32'hA);
    wr(OFS_MINPER, 32'h5);
    n0 = ls_cnt;
    wr(OFS_CMD, 32'h1);
    wait_gate(1'b1, 3);
    chk({31'h0, gate}, 32'h1);
    wait_gate(1'b0, 100);
    repeat (2) @(posedge clk);
    chk(32'(ls_cnt - n0), 32'h4);
    wait_gate(1'b1, 5);
    chk({31'h0, gate}, 32'h1);
    wait_ls(30, n);
    wait_ls(30, n);
    chk(32'(n), 32'hA);
    repeat (300) @(posedge clk);
    rd(OFS_STATUS, d);
    chk({31'h0, d[ST_ARMED_BIT]}, 32'h1);
    // Both bits set: disarm must win
    wr(OFS_CMD, 32'h3);
    repeat (2) @(posedge clk);
    n0 = ls_cnt;
    repeat (100) @(posedge clk);
    chk(32'(ls_cnt - n0), 32'h0);
    chk({30'h0, armed, gate}, 32'h0);
    wr(OFS_PERIOD, 32'h3);
    wr(OFS_MINPER, 32'h14);
    wr(OFS_CMD, 32'h1);
    wait_ls(100, n);
    wait_ls(100, n);
    chk(32'(n), 32'h14);
    wr(OFS_CMD, 32'h2);
  endtask : test_freerun

  task automatic test_ext_edge();
    int n0;
    logic [31:0] d;
    cfg(TGT_FRAME, 1'b1, 1'b0, ACT_RISE);
    cfg(TGT_LINE, 1'b1, 1'b1, ACT_RISE);
    wr(OFS_HEIGHT, 32'h3);
    wr(OFS_CMD, 32'h1);
    repeat (10) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    n0 = ls_cnt;
    SRC.pulse(1'b1, 60, 60);
    chk(32'(ls_cnt - n0), 32'h0);
    SRC.pulse(1'b0, 20, 100);
    chk({31'h0, gate}, 32'h0);
    SRC.pulse(1'b0, 60, 60);
    chk({31'h0, gate}, 32'h1);
    rd(OFS_STATUS, d);
    chk({30'h0, d[ST_GATE_BIT], d[ST_ARMED_BIT]}, 32'h3);
    n0 = ls_cnt;
    repeat (3) SRC.pulse(1'b1, 60, 60);
    chk(32'(ls_cnt - n0), 32'h3);
    chk({31'h0, gate}, 32'h0);
    // Level codes are not legal for line starts
    wr(OFS_SEL, 32'h1);
    wr(OFS_ACT, 32'h3);
    rd(OFS_ACT, d);
    chk(d, {29'h0, ACT_RISE});
    wr(OFS_CMD, 32'h2);
  endtask : test_ext_edge

  task automatic test_levels();
    int n0;
    logic [31:0] d;
    act_t acts[3] = '{ACT_RISE, ACT_FALL, ACT_ANY};
    cfg(TGT_FRAME, 1'b1, 1'b0, ACT_HIGH);
    wr(OFS_CMD, 32'h1);
    SRC.drive(1'b0, 1'b1, 60);
    chk({31'h0, gate}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      cfg(TGT_LINE, 1'b1, 1'b1, acts[i]);
      n0 = ls_cnt;
      SRC.pulse(1'b1, 60, 60);
      chk(32'(ls_cnt - n0), (i == 2) ? 32'h2 : 32'h1);
    end
    wr(OFS_SEL, 32'h0);
    rd(OFS_ACT, d);
    chk(d, {29'h0, ACT_HIGH});
    SRC.drive(1'b0, 1'b0, 60);
    chk({31'h0, gate}, 32'h0);
    cfg(TGT_FRAME, 1'b1, 1'b1, ACT_LOW);
    cfg(TGT_LINE, 1'b1, 1'b0, ACT_RISE);
    SRC.drive(1'b1, 1'b1, 60);
    chk({31'h0, gate}, 32'h0);
    SRC.drive(1'b1, 1'b0, 60);
    chk({31'h0, gate}, 32'h1);
    n0 = ls_cnt;
    SRC.pulse(1'b0, 60, 60);
    chk(32'(ls_cnt - n0), 32'h1);
    SRC.drive(1'b1, 1'b1, 60);
    chk({31'h0, gate}, 32'h0);
    wr(OFS_CMD, 32'h2);
  endtask : test_levels

  // Frame on input b: any edge first, then falling edge only
  task automatic test_frame_edges();
    int n0;
    logic [31:0] d;
    cfg(TGT_FRAME, 1'b1, 1'b1, ACT_ANY);
    cfg(TGT_LINE, 1'b1, 1'b0, ACT_RISE);
    wr(OFS_HEIGHT, 32'h2);
    wr(OFS_CMD, 32'h1);
    SRC.drive(1'b1, 1'b0, 60);
    chk({31'h0, gate}, 32'h1);
    n0 = ls_cnt;
    SRC.pulse(1'b0, 60, 60);
    rd(OFS_STATUS, d);
    chk({16'h0, d[ST_CNT_LSB +: 16]}, 32'h1);
    SRC.pulse(1'b0, 60, 60);
    chk(32'(ls_cnt - n0), 32'h2);
    chk({31'h0, gate}, 32'h0);
    SRC.drive(1'b1, 1'b1, 60);
    chk({31'h0, gate}, 32'h1);
    wr(OFS_SEL, 32'h0);
    wr(OFS_ACT, {29'h0, ACT_FALL});
    repeat (2) SRC.pulse(1'b0, 60, 60);
    chk({31'h0, gate}, 32'h0);
    SRC.drive(1'b1, 1'b0, 60);
    chk({31'h0, gate}, 32'h1);
    repeat (2) SRC.pulse(1'b0, 60, 60);
    chk({31'h0, gate}, 32'h0);
    SRC.drive(1'b1, 1'b1, 60);
    chk({31'h0, gate}, 32'h0);
    wr(OFS_CMD, 32'h2);
  endtask : test_frame_edges

  initial begin
    srst = 1'b1;
    req = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    test_reset();
    test_freerun();
    test_ext_edge();
    test_levels();
    test_frame_edges();
    report_and_stop();
  end

  // Whole run needs a few thousand cycles
  initial begin
    #(25 * 20000);
    fail_count++;
    report_and_stop();
  end
endmodule : line_scan_acquisition_trigger_ctrl_tb_top
`default_nettype wire
